// file: hdl/batch_cfg.svh
// Addresses, field positions, reset values and timing of the batch sequencer.
// Included by the package, the sequencer and the bench; definitions only.
`ifndef BATCH_CFG_SVH
`define BATCH_CFG_SVH
`define ADDR_CTRL       12'h000
`define ADDR_STATUS     12'h004
`define ADDR_TOTAL      12'h008
`define ADDR_CYCLES     12'h00c
`define ADDR_DELAY2     12'h010
`define ADDR_EARLY2     12'h014
`define ADDR_DELAY3     12'h018
`define ADDR_EARLY3     12'h01c
`define ADDR_RESTART    12'h020
`define ADDR_LIMIT      12'h024
`define ADDR_SELECT     12'h028
`define ADDR_OPCODE     12'h02c
`define ADDR_CFGCODE    12'h030
`define ADDR_ENTRY      12'h034
`define ADDR_SETPOINT   12'h040
`define ADDR_HISTORY    12'h080
`define ADDR_NAME       12'h100
`define NUM_SETPOINTS   9
`define HIST_DEPTH      10
`define NAME_WORDS      4
`define CTRL_RESET      32'h0000_00f0
`define CTRL_QUICK      0
`define CTRL_AUTO       1
`define CTRL_OPCODE_EN  2
`define CTRL_CFGCODE_EN 3
`define CTRL_MENU_LSB   4
`define CTRL_OUT2_LSB   8
`define CTRL_OUT3_LSB   10
`define ENTRY_TARGET    16
`define ENTRY_CLOSE     17
`define LIMIT_RESET     16'h0001
`define CLK_PERIOD_NS   20
`define MS_NS           1000000
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10
`define RESP_DECERR     2'b11
`endif

// file: hdl/batch_pkg.sv
// Types shared by the batch sequencer: phases, output modes, state record.
// Assumes batch_cfg.svh is on the include path.
`include "batch_cfg.svh"
package batch_pkg;
  typedef enum logic [2:0] {
    PH_READY    = 3'b000,
    PH_RUNNING  = 3'b001,
    PH_COMPLETE = 3'b011,
    PH_WAITING  = 3'b010,
    PH_PAUSED   = 3'b101
  } phase_e;
  typedef enum logic [1:0] {
    OM_CONTROL = 2'b00,
    OM_PULSE   = 2'b01,
    OM_STATUS  = 2'b10,
    OM_OFF     = 2'b11
  } out_mode_e;
  typedef logic [`NAME_WORDS-1:0][31:0] name_t;
  typedef struct packed {
    phase_e                             phase;
    logic [31:0]                        total;
    logic [15:0]                        cyclesDone;
    logic [15:0]                        runMs;
    logic [15:0]                        waitMs;
    logic [31:0]                        msDiv;
    logic                               primary;
    logic [1:0]                         aux;
    logic [1:0]                         savedPhase;
    logic                               autoHalt;
    logic                               restoreOpen;
    logic                               opOpen;
    logic                               cfgOpen;
    logic                               menuPending;
    logic [31:0]                        ctrl;
    logic [1:0][15:0]                   delay;
    logic [1:0][31:0]                   early;
    logic [15:0]                        restartMs;
    logic [15:0]                        cycleLimit;
    logic [3:0]                         select;
    logic [15:0]                        opCode;
    logic [15:0]                        cfgCode;
    logic [`NUM_SETPOINTS-1:0][31:0]    setpoint;
    name_t [`NUM_SETPOINTS-1:0]         name;
    logic [`HIST_DEPTH-1:0][31:0]       history;
    logic                               awHave;
    logic                               wHave;
    logic [11:0]                        awAddr;
    logic [31:0]                        wData;
    logic [3:0]                         wStrb;
    logic                               bvalid;
    logic [1:0]                         bresp;
    logic                               rvalid;
    logic [31:0]                        rdata;
    logic [1:0]                         rresp;
  } state_s;
endpackage

// file: hdl/batch_dispense_sequencer.sv
// Batch dispensing sequencer with its AXI4-Lite register file.
// Buttons and flow increments are one-cycle pulses synchronous to clock;
// retained values live in an external non-volatile store.
//
// Our own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "batch_cfg.svh"
module batch_dispense_sequencer
  import batch_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `MS_NS / `CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // Operator buttons and security link
  input  wire logic        startBtn,
  input  wire logic        stopBtn,
  input  wire logic        resetBtn,
  input  wire logic        menuBtn,
  input  wire logic        securityLink,
  // Scaled flow increments
  input  wire logic        flowValid,
  input  wire logic [15:0] flowInc,
  // Valve and auxiliary outputs
  output logic             primaryValve,
  output logic             output2,
  output logic             output3,
  // Retained values and their restore after power-up
  output logic [1:0]       savedPhase,
  output logic [31:0]      savedTotal,
  output logic [15:0]      savedCycles,
  input  wire logic        restoreStrobe,
  input  wire logic [1:0]  restorePhase,
  input  wire logic [31:0] restoreTotal,
  input  wire logic [15:0] restoreCycles,
  // AXI4-Lite slave
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [11:0] awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [11:0] araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp
);

  state_s s_reg;
  state_s s_next;

  function automatic logic inRange(input logic [11:0] a,
                                   input logic [11:0] base,
                                   input int unsigned words);
    return (a >= base) && (a < base + 12'(words * 4)) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic [5:0] wordIndex(input logic [11:0] a,
                                           input logic [11:0] base);
    logic [11:0] d;
    d = a - base;
    return d[7:2];
  endfunction

  function automatic logic [31:0] subSat(input logic [31:0] a,
                                         input logic [31:0] b);
    return (a > b) ? a - b : 32'h0000_0000;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [1:0] phaseClass(input phase_e p);
    case (p)
      PH_READY:    return 2'b00;
      PH_COMPLETE: return 2'b10;
      default:     return 2'b01;
    endcase
  endfunction

  logic        msTick;
  logic [31:0] target;
  logic [3:0]  menuItems;
  logic        counting;
  logic        batchDone;

  always_comb begin
    logic [31:0] wd;
    logic [11:0] wa;
    logic [5:0]  wi;
    logic [5:0]  ri;
    logic        cfgOk;
    logic        started;
    out_mode_e   mode;
    wd      = 32'h0000_0000;
    wa      = 12'h000;
    wi      = 6'h00;
    ri      = 6'h00;
    started = 1'b0;
    mode    = OM_OFF;
    s_next  = s_reg;
    cfgOk   = s_reg.cfgOpen;
    msTick  = (s_reg.msDiv == 32'(MS_CYCLES - 1));
    s_next.msDiv = msTick ? 32'h0000_0000 : s_reg.msDiv + 32'h0000_0001;
    target  = (s_reg.select < 4'(`NUM_SETPOINTS)) ?
              s_reg.setpoint[s_reg.select] : 32'h0000_0000;
    menuItems = s_reg.opOpen ? s_reg.ctrl[`CTRL_MENU_LSB +: 4] : 4'h0;
    counting  = (s_reg.phase == PH_RUNNING) || (s_reg.phase == PH_PAUSED);
    batchDone = (s_reg.total >= target);

    if (counting && flowValid) begin
      s_next.total = s_reg.total + {16'h0000, flowInc};
    end
    if (s_reg.phase == PH_RUNNING && msTick && s_reg.runMs != 16'hffff) begin
      s_next.runMs = s_reg.runMs + 16'h0001;
    end
    if (s_reg.phase == PH_WAITING && msTick && s_reg.waitMs != 16'hffff) begin
      s_next.waitMs = s_reg.waitMs + 16'h0001;
    end

    if (restoreStrobe && s_reg.restoreOpen && s_reg.phase == PH_READY) begin
      s_next.restoreOpen = 1'b0;
      s_next.total       = restoreTotal;
      s_next.cyclesDone  = restoreCycles;
      case (restorePhase)
        2'b01:   s_next.phase = PH_PAUSED;
        2'b10:   s_next.phase = PH_COMPLETE;
        default: s_next.phase = PH_READY;
      endcase
    end else begin
      case (s_reg.phase)
        PH_READY: begin
          if (startBtn && !stopBtn) begin
            started = 1'b1;
          end
        end
        PH_RUNNING: begin
          if (stopBtn) begin
            s_next.phase = PH_PAUSED;
          end else if (batchDone) begin
            s_next.phase      = PH_COMPLETE;
            s_next.cyclesDone = s_reg.cyclesDone + 16'h0001;
            for (int i = `HIST_DEPTH - 1; i > 0; i--) begin
              s_next.history[i] = s_reg.history[i-1];
            end
            s_next.history[0] = s_reg.total;
          end
        end
        PH_PAUSED: begin
          if (resetBtn) begin
            s_next.phase      = PH_READY;
            s_next.total      = 32'h0000_0000;
            s_next.cyclesDone = 16'h0000;
            s_next.autoHalt   = 1'b0;
          end else if (startBtn && !stopBtn) begin
            s_next.phase = PH_RUNNING;
          end
        end
        PH_COMPLETE: begin
          if (resetBtn) begin
            s_next.phase      = PH_READY;
            s_next.total      = 32'h0000_0000;
            s_next.cyclesDone = 16'h0000;
            s_next.autoHalt   = 1'b0;
          end else if (startBtn && s_reg.ctrl[`CTRL_QUICK]) begin
            started = 1'b1;
          end else if (s_reg.ctrl[`CTRL_AUTO] && !s_reg.autoHalt &&
                       s_reg.cyclesDone < s_reg.cycleLimit) begin
            s_next.phase  = PH_WAITING;
            s_next.waitMs = 16'h0000;
          end
        end
        PH_WAITING: begin
          if (resetBtn) begin
            s_next.phase      = PH_READY;
            s_next.total      = 32'h0000_0000;
            s_next.cyclesDone = 16'h0000;
          end else if (stopBtn) begin
            s_next.phase    = PH_COMPLETE;
            s_next.autoHalt = 1'b1;
          end else if (s_reg.waitMs >= s_reg.restartMs) begin
            started = 1'b1;
          end
        end
        default: begin
          s_next.phase = PH_READY;
        end
      endcase
    end
    if (started) begin
      s_next.phase       = PH_RUNNING;
      s_next.total       = 32'h0000_0000;
      s_next.runMs       = 16'h0000;
      s_next.restoreOpen = 1'b0;
    end

    s_next.primary = (s_next.phase == PH_RUNNING) &&
                     (s_next.total < target);
    for (int k = 0; k < 2; k++) begin
      mode = out_mode_e'(s_reg.ctrl[`CTRL_OUT2_LSB + 2*k +: 2]);
      case (mode)
        OM_CONTROL: begin
          s_next.aux[k] = (s_next.phase == PH_RUNNING) &&
                          (s_next.runMs >= s_reg.delay[k]) &&
                          (s_next.total < subSat(target, s_reg.early[k]));
        end
        OM_PULSE:  s_next.aux[k] = counting && flowValid;
        OM_STATUS: s_next.aux[k] = (s_next.phase == PH_RUNNING) ||
                                   (s_next.phase == PH_PAUSED);
        default:   s_next.aux[k] = 1'b0;
      endcase
    end
    s_next.savedPhase = phaseClass(s_next.phase);

    if (!securityLink) begin
      s_next.cfgOpen = 1'b0;
    end

    if (awvalid && awready) begin
      s_next.awHave = 1'b1;
      s_next.awAddr = awaddr;
    end
    if (wvalid && wready) begin
      s_next.wHave = 1'b1;
      s_next.wData = wdata;
      s_next.wStrb = wstrb;
    end
    if (s_reg.bvalid && bready) begin
      s_next.bvalid = 1'b0;
    end
    if (s_next.awHave && s_next.wHave) begin
      wa = s_next.awAddr;
      s_next.awHave = 1'b0;
      s_next.wHave  = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp  = `RESP_SLVERR;
      if (inRange(wa, `ADDR_SETPOINT, `NUM_SETPOINTS)) begin
        wi = wordIndex(wa, `ADDR_SETPOINT);
        if (cfgOk || menuItems[1]) begin
          s_next.setpoint[wi] = merge(s_reg.setpoint[wi], s_next.wData,
                                      s_next.wStrb);
          s_next.bresp = `RESP_OKAY;
        end
      end else if (inRange(wa, `ADDR_NAME,
                           `NUM_SETPOINTS * `NAME_WORDS)) begin
        wi = wordIndex(wa, `ADDR_NAME);
        if (cfgOk) begin
          s_next.name[wi[5:2]][wi[1:0]] =
            merge(s_reg.name[wi[5:2]][wi[1:0]], s_next.wData, s_next.wStrb);
          s_next.bresp = `RESP_OKAY;
        end
      end else begin
        wd = s_next.wData;
        if (wa == `ADDR_SELECT || wa == `ADDR_ENTRY) begin
          s_next.bresp = `RESP_SLVERR;
        end else if (!cfgOk) begin
          s_next.bresp = `RESP_SLVERR;
        end else begin
          s_next.bresp = `RESP_OKAY;
        end
        case (wa)
          `ADDR_CTRL:    if (cfgOk) s_next.ctrl = merge(s_reg.ctrl, wd,
                                                        s_next.wStrb);
          `ADDR_DELAY2:  if (cfgOk) s_next.delay[0] = wd[15:0];
          `ADDR_EARLY2:  if (cfgOk) s_next.early[0] = wd;
          `ADDR_DELAY3:  if (cfgOk) s_next.delay[1] = wd[15:0];
          `ADDR_EARLY3:  if (cfgOk) s_next.early[1] = wd;
          `ADDR_RESTART: if (cfgOk) s_next.restartMs = wd[15:0];
          `ADDR_LIMIT:   if (cfgOk) s_next.cycleLimit = wd[15:0];
          `ADDR_OPCODE:  if (cfgOk) s_next.opCode = wd[15:0];
          `ADDR_CFGCODE: if (cfgOk) s_next.cfgCode = wd[15:0];
          `ADDR_SELECT: begin
            if ((cfgOk || menuItems[0]) &&
                wd[3:0] < 4'(`NUM_SETPOINTS)) begin
              s_next.select = wd[3:0];
              s_next.bresp  = `RESP_OKAY;
            end
          end
          `ADDR_ENTRY: begin
            if (wd[`ENTRY_CLOSE]) begin
              s_next.opOpen      = 1'b0;
              s_next.cfgOpen     = 1'b0;
              s_next.menuPending = 1'b0;
              s_next.bresp       = `RESP_OKAY;
            end else if (!wd[`ENTRY_TARGET]) begin
              if (s_reg.menuPending && wd[15:0] == s_reg.opCode) begin
                s_next.opOpen      = 1'b1;
                s_next.menuPending = 1'b0;
                s_next.bresp       = `RESP_OKAY;
              end
            end else begin
              if (securityLink && menuItems[3] &&
                  (!s_reg.ctrl[`CTRL_CFGCODE_EN] ||
                   wd[15:0] == s_reg.cfgCode)) begin
                s_next.cfgOpen = 1'b1;
                s_next.bresp   = `RESP_OKAY;
              end
            end
          end
          `ADDR_STATUS, `ADDR_TOTAL, `ADDR_CYCLES: s_next.bresp = `RESP_SLVERR;
          default: s_next.bresp = inRange(wa, `ADDR_HISTORY, `HIST_DEPTH) ?
                                  `RESP_SLVERR : `RESP_DECERR;
        endcase
      end
    end

    // A press wins over a close written in the same cycle.
    // menu code gate
    if (menuBtn) begin
      if (s_reg.ctrl[`CTRL_OPCODE_EN]) begin
        s_next.menuPending = 1'b1;
      end else begin
        s_next.opOpen = 1'b1;
      end
    end

    if (s_reg.rvalid && rready) begin
      s_next.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      s_next.rvalid = 1'b1;
      s_next.rresp  = `RESP_OKAY;
      s_next.rdata  = 32'h0000_0000;
      if (inRange(araddr, `ADDR_SETPOINT, `NUM_SETPOINTS)) begin
        ri = wordIndex(araddr, `ADDR_SETPOINT);
        s_next.rdata = s_reg.setpoint[ri];
      end else if (inRange(araddr, `ADDR_HISTORY, `HIST_DEPTH)) begin
        ri = wordIndex(araddr, `ADDR_HISTORY);
        if (cfgOk || menuItems[2]) begin
          s_next.rdata = s_reg.history[ri];
        end
      end else if (inRange(araddr, `ADDR_NAME,
                           `NUM_SETPOINTS * `NAME_WORDS)) begin
        ri = wordIndex(araddr, `ADDR_NAME);
        s_next.rdata = s_reg.name[ri[5:2]][ri[1:0]];
      end else begin
        case (araddr)
          `ADDR_CTRL:    s_next.rdata = s_reg.ctrl;
          `ADDR_STATUS:  s_next.rdata = {17'h00000, s_reg.autoHalt,
                                         s_reg.select, securityLink,
                                         s_reg.menuPending, s_reg.cfgOpen,
                                         s_reg.opOpen, s_reg.aux,
                                         s_reg.primary, s_reg.phase};
          `ADDR_TOTAL:   s_next.rdata = s_reg.total;
          `ADDR_CYCLES:  s_next.rdata = {16'h0000, s_reg.cyclesDone};
          `ADDR_DELAY2:  s_next.rdata = {16'h0000, s_reg.delay[0]};
          `ADDR_EARLY2:  s_next.rdata = s_reg.early[0];
          `ADDR_DELAY3:  s_next.rdata = {16'h0000, s_reg.delay[1]};
          `ADDR_EARLY3:  s_next.rdata = s_reg.early[1];
          `ADDR_RESTART: s_next.rdata = {16'h0000, s_reg.restartMs};
          `ADDR_LIMIT:   s_next.rdata = {16'h0000, s_reg.cycleLimit};
          `ADDR_SELECT:  s_next.rdata = {28'h0000000, s_reg.select};
          `ADDR_OPCODE, `ADDR_CFGCODE, `ADDR_ENTRY: s_next.rdata = 32'h0;
          default:       s_next.rresp = `RESP_DECERR;
        endcase
      end
    end
  end

  // Codes read back as zero so the bus cannot leak them.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s_reg             <= '0;
      s_reg.ctrl        <= `CTRL_RESET;
      s_reg.cycleLimit  <= `LIMIT_RESET;
      s_reg.restoreOpen <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign awready      = !s_reg.awHave && !s_reg.bvalid;
  assign wready       = !s_reg.wHave && !s_reg.bvalid;
  assign bvalid       = s_reg.bvalid;
  assign bresp        = s_reg.bresp;
  assign arready      = !s_reg.rvalid;
  assign rvalid       = s_reg.rvalid;
  assign rdata        = s_reg.rdata;
  assign rresp        = s_reg.rresp;
  assign primaryValve = s_reg.primary;
  assign output2      = s_reg.aux[0];
  assign output3      = s_reg.aux[1];
  assign savedPhase   = s_reg.savedPhase;
  assign savedTotal   = s_reg.total;
  assign savedCycles  = s_reg.cyclesDone;

endmodule

// file: verification/batch_seq_chk.sv
// Port checker for the batch sequencer, bound beside every instance.
// Assumes buttons and flow increments arrive as one-cycle pulses.
`timescale 1ns/1ps
module batch_seq_chk #(
  parameter int unsigned MS_CYCLES = 50000
) (
  // Clock, reset, buttons, restore strobe and flow increments
  input wire logic        clock, rst_b, startBtn, stopBtn, resetBtn,
  input wire logic        restoreStrobe, flowValid,
  input wire logic [15:0] flowInc,
  // Sequencer outputs
  input wire logic        primaryValve,
  input wire logic [1:0]  savedPhase,
  input wire logic [31:0] savedTotal,
  // Register bus handshakes
  input wire logic        awvalid, awready, wvalid, wready, bvalid,
  input wire logic        arvalid, arready, rvalid
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  property p_rst;
    $rose(rst_b) |-> savedPhase == 2'h0 && !primaryValve && awready;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  property p_start;
    savedPhase == 2'h0 && startBtn && !stopBtn && !resetBtn
      |=> primaryValve && savedPhase == 2'h1;
  endproperty
  a_start: assert property (p_start) else $error("start lost");
  property p_stop;
    stopBtn && primaryValve |=> !primaryValve && savedPhase == 2'h1;
  endproperty
  a_stop: assert property (p_stop) else $error("stop late");
  property p_done;
    savedPhase == 2'h2 |-> !primaryValve;
  endproperty
  a_done: assert property (p_done) else $error("valve on");
  property p_idle;
    savedPhase == 2'h0 && !startBtn && !restoreStrobe |=> $stable(savedTotal);
  endproperty
  a_idle: assert property (p_idle) else $error("ready counted");
  property p_count;
    savedPhase == 2'h1 && primaryValve && flowValid && !stopBtn && !resetBtn
      |=> savedTotal == $past(savedTotal) + 32'($past(flowInc));
  endproperty
  a_count: assert property (p_count) else $error("bad sum");
  property p_clear;
    savedPhase == 2'h2 && resetBtn && !stopBtn |=> savedPhase == 2'h0;
  endproperty
  a_clear: assert property (p_clear) else $error("no ready");
  property p_bans;
    awvalid && awready && wvalid && wready |=> bvalid;
  endproperty
  a_bans: assert property (p_bans) else $error("no write answer");
  property p_rans;
    arvalid && arready |=> rvalid && !arready;
  endproperty
  a_rans: assert property (p_rans) else $error("no read answer");
endmodule
bind batch_dispense_sequencer batch_seq_chk #(.MS_CYCLES(MS_CYCLES))
  i_batch_seq_chk (.clock, .rst_b, .startBtn, .stopBtn, .resetBtn,
  .restoreStrobe, .flowValid, .flowInc, .primaryValve, .savedPhase,
  .savedTotal, .awvalid, .awready, .wvalid, .wready, .bvalid, .arvalid,
  .arready, .rvalid);

// file: verification/flow_meter.sv
// Behavioural flowmeter giving scaled increments on the rising edge.
// Driven by bench calls to burst; idle between bursts.
`timescale 1ns/1ps
module flow_meter (
  // Clock and flow increments
  input  wire logic        clock,
  output logic             flowValid,
  output logic [15:0]      flowInc
);
  initial begin
    flowValid = 1'b0;
    flowInc   = 16'h0;
  end
  // Gap 0 gives back-to-back pulses; outside a pulse the bus holds junk.
  task automatic burst(input int n, input logic [15:0] inc, input int gap);
    repeat (n) begin
      @(posedge clock);
      flowValid <= 1'b1;
      flowInc   <= inc;
      if (gap > 0) begin
        @(posedge clock);
        flowValid <= 1'b0;
        flowInc   <= ~inc;
        repeat (gap - 1) @(posedge clock);
      end
    end
    @(posedge clock);
    flowValid <= 1'b0;
    flowInc   <= ~inc;
  endtask
endmodule

// file: verification/tb_top.sv
// Self-checking bench for the batch sequencer over its register bus.
// Assumes the flow meter model and the bound checker are compiled first.
`timescale 1ns/1ps
`include "batch_cfg.svh"
`define CHK(n, e, g) begin checkCount++; if ((g) !== (e)) begin \
  mismatches++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_top;
  import batch_pkg::*;
  logic clock = 1'b0, rst_b = 1'b0, securityLink = 1'b0;
  logic restoreStrobe = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  logic [1:0] restorePhase = 2'h0;
  logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [3:0] btn = 4'h0;
  logic [11:0] addr = 12'h0;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, primaryValve, output2;
  logic flowValid, output3;
  logic [1:0] bresp, rresp;
  logic [15:0] flowInc, savedCycles;
  logic [31:0] rdata;
  int mismatches = 0, checkCount = 0, cycles = 0;
  always #10 clock = ~clock;
  batch_dispense_sequencer #(.MS_CYCLES(5)) i_batch_dispense_sequencer (
    .clock, .rst_b, .startBtn(btn[0]), .stopBtn(btn[1]), .resetBtn(btn[2]),
    .menuBtn(btn[3]), .securityLink, .flowValid, .flowInc, .primaryValve,
    .output2, .output3, .savedPhase(), .savedTotal(), .savedCycles,
    .restoreStrobe, .restorePhase, .restoreTotal(32'h7),
    .restoreCycles(16'h0), .awvalid, .awready, .awaddr(addr), .wvalid,
    .wready, .wdata, .wstrb(4'hf), .bvalid, .bready, .bresp, .arvalid,
    .arready, .araddr(addr), .rvalid, .rready, .rdata, .rresp);
  flow_meter i_flow_meter (.clock, .flowValid, .flowInc);
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] er = 2'h0);
    @(posedge clock);
    addr    <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    while (!bvalid) @(posedge clock);
    bready <= 1'b0;
    `CHK("bresp", er, bresp)
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input logic [31:0] m = 32'hffffffff,
                    input logic [1:0] er = 2'h0);
    @(posedge clock);
    addr    <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge clock); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge clock);
    rready <= 1'b0;
    `CHK("rdata", e, rdata & m)
    `CHK("rresp", er, rresp)
  endtask
  // Index 0 start, 1 stop, 2 reset, 3 menu; returns with outputs settled.
  task automatic press(input int k);
    @(posedge clock);
    btn[k] <= 1'b1;
    @(posedge clock);
    btn[k] <= 1'b0;
    @(negedge clock);
  endtask
  // Cuts the supply, then offers the retained phase once after release.
  task automatic restore(input logic [1:0] ph);
    rst_b        <= 1'b0;
    restorePhase <= ph;
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    restoreStrobe <= 1'b1;
    @(posedge clock);
    restoreStrobe <= 1'b0;
  endtask
  task automatic complete_run;
    if (mismatches == 0 && checkCount > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      complete_run();
    end
  end
  initial begin
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    rd(`ADDR_CTRL, `CTRL_RESET);
    rd(`ADDR_LIMIT, 32'h1);
    rd(12'h0fc, 32'h0, 32'h0, `RESP_DECERR);
    wr(`ADDR_STATUS, 32'h1, `RESP_SLVERR);
    wr(`ADDR_DELAY2, 32'h2, `RESP_SLVERR);
    securityLink <= 1'b1;
    press(3);
    wr(`ADDR_ENTRY, 32'h10000);
    wr(`ADDR_DELAY2, 32'h2);
    wr(`ADDR_EARLY2, 32'h4);
    wr(`ADDR_SETPOINT, 32'h63);
    wr(`ADDR_SETPOINT + 12'h4, 32'h14);
    wr(`ADDR_SELECT, 32'h1);
    wr(`ADDR_NAME + 12'h1c, 32'h41424344);
    rd(`ADDR_NAME + 12'h1c, 32'h41424344);
    wr(`ADDR_OPCODE, 32'h1234);
    wr(`ADDR_CTRL, 32'hf4);
    wr(`ADDR_ENTRY, 32'h20000);
    press(3);
    wr(`ADDR_ENTRY, 32'h1235, `RESP_SLVERR);
    wr(`ADDR_ENTRY, 32'h1234);
    wr(`ADDR_SELECT, 32'h1);
    wr(`ADDR_ENTRY, 32'h10000);
    press(0);
    `CHK("primary", 1'b1, primaryValve)
    `CHK("out2", 1'b0, output2)
    repeat (14) @(negedge clock);
    `CHK("out2", 1'b1, output2)
    i_flow_meter.burst(4, 16'h4, 0);
    repeat (2) @(negedge clock);
    `CHK("out2", 1'b0, output2)
    `CHK("primary", 1'b1, primaryValve)
    i_flow_meter.burst(1, 16'h4, 3);
    rd(`ADDR_STATUS, 32'h3, 32'h7);
    rd(`ADDR_HISTORY, 32'h14);
    press(0);
    rd(`ADDR_STATUS, 32'h3, 32'h7);
    press(2);
    i_flow_meter.burst(2, 16'h5, 1);
    rd(`ADDR_STATUS, 32'h0, 32'h7);
    press(0);
    i_flow_meter.burst(2, 16'h3, 0);
    press(1);
    `CHK("primary", 1'b0, primaryValve)
    i_flow_meter.burst(2, 16'h2, 2);
    rd(`ADDR_STATUS, 32'h5, 32'h7);
    rd(`ADDR_TOTAL, 32'ha);
    press(0);
    `CHK("primary", 1'b1, primaryValve)
    press(1);
    press(2);
    rd(`ADDR_STATUS, 32'h0, 32'h7);
    wr(`ADDR_CTRL, 32'h9f1);
    press(0);
    `CHK("out3", 1'b1, output3)
    i_flow_meter.burst(5, 16'h4, 0);
    @(negedge clock);
    `CHK("out2", 1'b1, output2)
    rd(`ADDR_TOTAL, 32'h14);
    press(0);
    rd(`ADDR_TOTAL, 32'h0);
    press(1);
    press(2);
    wr(`ADDR_CTRL, 32'hf2);
    wr(`ADDR_LIMIT, 32'h2);
    wr(`ADDR_RESTART, 32'h3);
    press(0);
    i_flow_meter.burst(5, 16'h4, 1);
    rd(`ADDR_STATUS, 32'h2, 32'h7);
    repeat (24) @(negedge clock);
    `CHK("primary", 1'b1, primaryValve)
    i_flow_meter.burst(5, 16'h4, 0);
    repeat (24) @(negedge clock);
    rd(`ADDR_STATUS, 32'h3, 32'h7);
    rd(`ADDR_CYCLES, 32'h2);
    `CHK("cycles", 16'h2, savedCycles)
    securityLink <= 1'b0;
    wr(`ADDR_DELAY3, 32'h1, `RESP_SLVERR);
    restore(2'h1);
    rd(`ADDR_STATUS, 32'h5, 32'h7);
    rd(`ADDR_TOTAL, 32'h7);
    press(0);
    rd(`ADDR_STATUS, 32'h3, 32'h7);
    restore(2'h2);
    rd(`ADDR_STATUS, 32'h3, 32'h7);
    rd(`ADDR_TOTAL, 32'h7);
    complete_run();
  end
endmodule
